// ### logic/parallel_port_control.sv
// parallel port control, mode configuration and master/slave cycle engine
// What this block does
// - enable clear means no external access
// - stop-in-idle halts operation during idle
// - mux field places address on pins
// - buffer select chooses ttl or schmitt
// - write strobe pin driven only when enabled
// - read strobe pin driven only when enabled
// - chip-select function maps select pins
// - latch polarity sets address strobe level
// - polarity ignored on address-carrying pins
// - busy flag high during master transfer
// - interrupt mode 01 per cycle end
// - mode 10 on buffer three access
// - increment mode 11 steps legacy slave buffers
// - modes 01/10 step address bits
// - a14 excluded only when chip-select function is 10
// - mode 11 master with enable strobe
// - mode 10 master with split strobes
// - mode 01 addressable slave
// - mode 00 legacy slave
// - setup wait one to four cycles
// - zero strobe wait forces fixed setup, strobe and hold timing
`timescale 1ns/1ps
`include "port_ctrl_defines.svh"
module parallel_port_control (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // axi4-lite write
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [3:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // chip state
    input wire logic CHIP_IDLE,
    // port pins
    output logic [15:0] ADDR_OUT,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic [15:0] DATA_IN,
    input wire logic [1:0] SLAVE_ADDR_IN,
    output logic CS1_OUT,
    output logic CS2_OUT,
    output logic READ_STROBE_OUT,
    output logic READ_STROBE_OE,
    output logic WRITE_STROBE_OUT,
    output logic WRITE_STROBE_OE,
    output logic LATCH_LOW_OUT,
    output logic LATCH_HIGH_OUT,
    output logic TTL_SELECT,
    input wire logic SLAVE_READ_N,
    input wire logic SLAVE_WRITE_N,
    input wire logic SLAVE_CS_N,
    // event
    output logic CYCLE_EVENT
);
    import port_ctrl_pkg::*;

    logic [31:0] ctl, next_ctl;
    logic [31:0] mdc, next_mdc;
    logic [15:0] paddr, next_paddr;
    logic [15:0] pdata, next_pdata;
    logic [1:0] buf_ptr, next_buf_ptr;
    logic start_rd, start_wr, next_start_rd, next_start_wr;
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [3:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic bvalid_r, next_bvalid, rvalid_r, next_rvalid;
    logic [31:0] rdata_r, next_rdata;
    logic [1:0] bresp_r, next_bresp, rresp_r, next_rresp;
    logic arready_r, next_arready;

    cycle_state_t state, next_state;
    logic is_read, next_is_read;
    logic tmr_load;
    logic [3:0] tmr_count;
    logic tmr_done;
    logic [15:0] stepped_addr;

    wire en = ctl[`CTL_ENABLE];
    wire [1:0] mux = ctl[`CTL_MUX_LO +: 2];
    wire [1:0] chip_select_function = ctl[`CTL_CSF_LO +: 2];
    wire latch_polarity = ctl[`CTL_ALP];
    wire [1:0] interrupt_mode_sel = mdc[`MOD_INTERRUPT_MODE_SEL_LO +: 2];
    wire [1:0] address_step_mode = mdc[`MOD_ADDRESS_STEP_MODE_LO +: 2];
    mode_sel_t pmode;
    assign pmode = mdc[`MOD_MODE_LO +: 2];
    wire [1:0] setup_wait_cycles = mdc[`MOD_SETUP_WAIT_CYCLES_LO +: 2];
    wire [3:0] strobe_wait_cycles = mdc[`MOD_STROBE_WAIT_CYCLES_LO +: 4];
    wire [1:0] hold_wait_cycles = mdc[`MOD_HOLD_WAIT_CYCLES_LO +: 2];
    wire master = pmode[1];
    wire run = en && !(ctl[`CTL_STOP_IDLE] && CHIP_IDLE);
    wire busy = (state != ST_IDLE);

    wait_timer #(.WIDTH(4)) timer (
        .clk(MCLK),
        .rst_n(RST_N),
        .load(tmr_load),
        .count(tmr_count),
        .expired(tmr_done)
    );

    address_stepper stepper (
        .step_mode(address_step_mode),
        .a14_is_select(chip_select_function == 2'b10),
        .addr_in(paddr),
        .addr_out(stepped_addr)
    );

    // slave strobe edge detect; pins are synchronous inputs
    logic slv_act_d, next_slv_act_d;
    wire slv_act = pmode[1] == 1'b0 && !SLAVE_CS_N &&
                   (!SLAVE_READ_N || !SLAVE_WRITE_N);
    wire slv_done = slv_act_d && !slv_act && run;

    // bus slave and register file
    always_comb begin
        next_ctl = ctl;
        next_mdc = mdc;
        next_paddr = paddr;
        next_pdata = pdata;
        next_buf_ptr = buf_ptr;
        next_start_rd = 1'b0;
        next_start_wr = 1'b0;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_bvalid = bvalid_r;
        next_bresp = bresp_r;
        next_rvalid = rvalid_r;
        next_rdata = rdata_r;
        next_rresp = rresp_r;
        next_arready = 1'b0;
        next_slv_act_d = slv_act;
        if (AWVALID && AWREADY) begin
            next_aw_held = 1'b1;
            next_aw_addr = AWADDR;
        end
        if (WVALID && WREADY) begin
            next_w_held = 1'b1;
            next_w_data = WDATA;
        end
        if (aw_held && w_held && !bvalid_r) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = 2'b00;
            if (aw_addr == `OFF_PORT_CONTROL) begin
                next_ctl = w_data & `CTL_MASK;
            end else if (aw_addr == `OFF_PORT_MODE_CONFIG) begin
                // busy is read-only, keep hardware copy
                next_mdc = (w_data & `MOD_MASK) |
                           (mdc & ~`MOD_MASK);
            end else if (aw_addr == `OFF_PORT_ADDRESS) begin
                next_paddr = w_data[15:0];
            end else if (aw_addr == `OFF_PORT_DATA) begin
                next_pdata = w_data[15:0];
                // master write starts on a data write when idle
                next_start_wr = master && run && !busy;
            end else begin
                next_bresp = 2'b10;
            end
        end else if (bvalid_r && BREADY) begin
            next_bvalid = 1'b0;
        end
        if (ARVALID && !rvalid_r && !arready_r) begin
            next_arready = 1'b1;
            next_rvalid = 1'b1;
            next_rresp = 2'b00;
            if (ARADDR == `OFF_PORT_CONTROL) begin
                next_rdata = ctl;
            end else if (ARADDR == `OFF_PORT_MODE_CONFIG) begin
                next_rdata = mdc | {16'h0000, master && busy, 15'h0000};
            end else if (ARADDR == `OFF_PORT_ADDRESS) begin
                next_rdata = {16'h0000, paddr};
            end else if (ARADDR == `OFF_PORT_DATA) begin
                next_rdata = {16'h0000, pdata};
                next_start_rd = master && run && !busy;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = 2'b10;
            end
        end else if (rvalid_r && RREADY) begin
            next_rvalid = 1'b0;
        end
        if (state == ST_HOLD && tmr_done && is_read) begin
            next_pdata = DATA_IN;
        end
        if (state == ST_DONE) begin
            next_paddr = stepped_addr;
        end
        if (slv_act && run && !SLAVE_WRITE_N) begin
            next_pdata = {8'h00, DATA_IN[7:0]};
        end
        if (slv_done && pmode == 2'b00 && address_step_mode == 2'b11) begin
            next_buf_ptr = buf_ptr + 2'b01;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ctl <= `CTL_RESET;
            mdc <= `MOD_RESET;
            paddr <= 16'h0000;
            pdata <= 16'h0000;
            buf_ptr <= 2'b00;
            start_rd <= 1'b0;
            start_wr <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
            arready_r <= 1'b0;
            slv_act_d <= 1'b0;
        end else begin
            ctl <= next_ctl;
            mdc <= next_mdc;
            paddr <= next_paddr;
            pdata <= next_pdata;
            buf_ptr <= next_buf_ptr;
            start_rd <= next_start_rd;
            start_wr <= next_start_wr;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            bvalid_r <= next_bvalid;
            bresp_r <= next_bresp;
            rvalid_r <= next_rvalid;
            rdata_r <= next_rdata;
            rresp_r <= next_rresp;
            arready_r <= next_arready;
            slv_act_d <= next_slv_act_d;
        end
    end

    assign AWREADY = !aw_held;
    assign WREADY = !w_held;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;
    assign ARREADY = arready_r;

    // master cycle sequencer
    wire fixed = (strobe_wait_cycles == 4'h0);
    always_comb begin
        next_state = state;
        next_is_read = is_read;
        tmr_load = 1'b0;
        tmr_count = 4'h0;
        case (state)
            ST_IDLE: begin
                if (start_rd || start_wr) begin
                    next_is_read = start_rd;
                    tmr_load = 1'b1;
                    tmr_count = {2'b00, setup_wait_cycles} + 4'h1;
                    next_state = (mux != 2'b00) ? ST_ADDR : ST_SETUP;
                    if (mux == 2'b00) begin
                        tmr_count = fixed ? 4'h1 : {2'b00, setup_wait_cycles} + 4'h1;
                    end
                end
            end
            ST_ADDR: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_count = fixed ? 4'h1 : {2'b00, setup_wait_cycles} + 4'h1;
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_count = fixed ? 4'h1 : strobe_wait_cycles;
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_count = fixed ? (is_read ? 4'h0 : 4'h1)
                                      : {2'b00, hold_wait_cycles};
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (tmr_done) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!run) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            is_read <= 1'b0;
        end else begin
            state <= next_state;
            is_read <= next_is_read;
        end
    end

    // pin drivers
    logic [15:0] n_addr, n_data;
    logic n_doe, n_cs1, n_cs2, n_rd, n_rdoe, n_wr, n_wroe;
    logic n_all, n_alh, n_evt;
    wire in_addr = (state == ST_ADDR);
    wire strobe = (state == ST_STROBE);
    wire act = master && busy;
    always_comb begin
        n_addr = paddr;
        n_data = pdata;
        n_doe = act && !is_read && state != ST_IDLE;
        if (in_addr) begin
            n_doe = 1'b1;
            if (mux == 2'b01) begin
                n_data = {8'h00, paddr[7:0]};
            end else begin
                n_data = paddr;
            end
        end
        if (mux == 2'b10 || mux == 2'b11) begin
            n_addr = 16'h0000;
        end else if (mux == 2'b01) begin
            n_addr = {paddr[15:8], 8'h00};
        end
        if (!pmode[1]) begin
            // slave drives the data bus only on a host read
            n_doe = slv_act && !SLAVE_READ_N && run;
        end
        n_cs2 = (chip_select_function[1] || chip_select_function == 2'b01) ?
                (act ~^ ctl[`CTL_CS1P]) : paddr[15];
        n_cs1 = chip_select_function[1] ? (act ~^ ctl[`CTL_CS1P]) : paddr[14];
        if (pmode == 2'b11) begin
            n_rd = (is_read ^~ ctl[`CTL_RDSP]) && act;
            n_wr = (strobe ^~ ctl[`CTL_WRSP]);
        end else begin
            n_rd = (strobe && is_read && act) ^~ ctl[`CTL_RDSP];
            n_wr = (strobe && !is_read && act) ^~ ctl[`CTL_WRSP];
        end
        n_rdoe = ctl[`CTL_RDEN] && master && run;
        n_wroe = ctl[`CTL_WREN] && master && run;
        n_all = (in_addr && mux != 2'b00) ~^ latch_polarity;
        n_alh = (in_addr && mux == 2'b01) ~^ latch_polarity;
        n_evt = (interrupt_mode_sel == 2'b01 && (state == ST_DONE || slv_done)) ||
                (interrupt_mode_sel == 2'b10 && slv_done &&
                 ((pmode == 2'b00 && buf_ptr == 2'b11) ||
                  (pmode == 2'b01 && SLAVE_ADDR_IN == 2'b11)));
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ADDR_OUT <= 16'h0000;
            DATA_OUT <= 16'h0000;
            DATA_OE <= 1'b0;
            CS1_OUT <= 1'b0;
            CS2_OUT <= 1'b0;
            READ_STROBE_OUT <= 1'b0;
            READ_STROBE_OE <= 1'b0;
            WRITE_STROBE_OUT <= 1'b0;
            WRITE_STROBE_OE <= 1'b0;
            LATCH_LOW_OUT <= 1'b1;
            LATCH_HIGH_OUT <= 1'b1;
            TTL_SELECT <= 1'b0;
            CYCLE_EVENT <= 1'b0;
        end else begin
            ADDR_OUT <= n_addr;
            DATA_OUT <= n_data;
            DATA_OE <= n_doe;
            CS1_OUT <= n_cs1;
            CS2_OUT <= n_cs2;
            READ_STROBE_OUT <= n_rd;
            READ_STROBE_OE <= n_rdoe;
            WRITE_STROBE_OUT <= n_wr;
            WRITE_STROBE_OE <= n_wroe;
            LATCH_LOW_OUT <= n_all;
            LATCH_HIGH_OUT <= n_alh;
            TTL_SELECT <= ctl[`CTL_TTL];
            CYCLE_EVENT <= n_evt;
        end
    end
endmodule

// ### logic/port_ctrl_defines.svh
// register offsets, field positions, reset values and timing constants
`ifndef PORT_CTRL_DEFINES_SVH
`define PORT_CTRL_DEFINES_SVH
`define OFF_PORT_CONTROL 4'h0
`define OFF_PORT_MODE_CONFIG 4'h4
`define OFF_PORT_ADDRESS 4'h8
`define OFF_PORT_DATA 4'hC
`define CTL_ENABLE 15
`define CTL_STOP_IDLE 13
`define CTL_MUX_LO 11
`define CTL_TTL 10
`define CTL_WREN 9
`define CTL_RDEN 8
`define CTL_CSF_LO 6
`define CTL_ALP 5
`define CTL_CS1P 3
`define CTL_WRSP 1
`define CTL_RDSP 0
`define CTL_MASK 32'h0000_BFEB
`define MOD_BUSY 15
`define MOD_INTERRUPT_MODE_SEL_LO 13
`define MOD_ADDRESS_STEP_MODE_LO 11
`define MOD_MODE_LO 8
`define MOD_SETUP_WAIT_CYCLES_LO 6
`define MOD_STROBE_WAIT_CYCLES_LO 2
`define MOD_HOLD_WAIT_CYCLES_LO 0
`define MOD_MASK 32'h0000_7BFF
`define CTL_RESET 32'h0000_0000
`define MOD_RESET 32'h0000_0000
`define PERIPH_CLOCK_NS 4
`define MCLK_NS 4
`define PERIPH_CYCLES (`PERIPH_CLOCK_NS / `MCLK_NS)
`endif

// ### logic/port_ctrl_pkg.sv
// types shared by the parallel port files
package port_ctrl_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_ADDR = 6'b00_0010,
        ST_SETUP = 6'b00_0100,
        ST_STROBE = 6'b00_1000,
        ST_HOLD = 6'b01_0000,
        ST_DONE = 6'b10_0000
    } cycle_state_t;
    typedef logic [1:0] mode_sel_t;
endpackage

// ### logic/wait_timer.sv
// down counter that times the phases of one port cycle
`timescale 1ns/1ps
`include "port_ctrl_defines.svh"
module wait_timer #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic expired
);
    logic [WIDTH+1:0] remain;
    logic [WIDTH+1:0] next_remain;
    always_comb begin
        next_remain = remain;
        if (load) begin
            // each wait unit is one peripheral clock period
            next_remain = (WIDTH+2)'(count * `PERIPH_CYCLES);
        end else if (remain != '0) begin
            next_remain = remain - 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remain <= '0;
        end else begin
            remain <= next_remain;
        end
    end
    // expiry at one left, so a phase loaded with n of one or more lasts n cycles; not
    // looking at load keeps the sequencer free of a combinational loop
    assign expired = (remain[WIDTH+1:1] == '0);
endmodule

// ### logic/address_stepper.sv
// steps the port address after each cycle, keeping a15 fixed, and a14 when chip-select function is 10
`timescale 1ns/1ps
module address_stepper (
    // configuration
    input wire logic [1:0] step_mode,
    input wire logic a14_is_select,
    // address
    input wire logic [15:0] addr_in,
    output logic [15:0] addr_out
);
    logic [9:0] field;
    logic [9:0] stepped;
    always_comb begin
        // bit 14 sits above bits 10:2 so a carry out of bit 10 reaches it
        field = {addr_in[14], addr_in[10:2]};
        stepped = field;
        if (step_mode == 2'b01) begin
            stepped = field + 10'h001;
        end else if (step_mode == 2'b10) begin
            stepped = field - 10'h001;
        end
        addr_out = {addr_in[15], stepped[9], addr_in[13:11],
                    stepped[8:0], addr_in[1:0]};
        if (a14_is_select) begin
            // a14 used as a select line keeps its value
            addr_out[14] = addr_in[14];
        end
    end
endmodule

// ### sim/parallel_port_control_props.sv
// concurrent checks on the parallel port control pins
`timescale 1ns/1ps
module parallel_port_control_props (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // register bus
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    // pins
    input wire logic CHIP_IDLE,
    input wire logic [15:0] ADDR_OUT,
    input wire logic DATA_OE,
    input wire logic CS1_OUT,
    input wire logic CS2_OUT,
    input wire logic READ_STROBE_OE,
    input wire logic WRITE_STROBE_OUT,
    input wire logic WRITE_STROBE_OE,
    input wire logic LATCH_LOW_OUT,
    input wire logic LATCH_HIGH_OUT,
    input wire logic TTL_SELECT,
    input wire logic CYCLE_EVENT
);
    logic [3:0] aw_a, next_aw_a;
    logic [31:0] w_d, next_w_d, ctl, next_ctl, md, next_md;
    logic [1:0] hist, next_hist;
    logic settled;
    // shadows commit on the response, so judge only after two quiet cycles
    assign settled = !AWVALID && !WVALID && !BVALID && hist == 2'b00;
    always_comb begin
        next_aw_a = aw_a;
        next_w_d = w_d;
        next_ctl = ctl;
        next_md = md;
        next_hist = {hist[0], AWVALID | WVALID | BVALID};
        if (AWVALID && AWREADY) next_aw_a = AWADDR;
        if (WVALID && WREADY) next_w_d = WDATA;
        if (BVALID && BREADY && BRESP == 2'b00 && aw_a == 4'h0) next_ctl = w_d;
        if (BVALID && BREADY && BRESP == 2'b00 && aw_a == 4'h4) next_md = w_d;
    end
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            aw_a <= 4'h0;
            w_d <= 32'h0000_0000;
            ctl <= 32'h0000_0000;
            md <= 32'h0000_0000;
            hist <= 2'b00;
        end else begin
            aw_a <= next_aw_a;
            w_d <= next_w_d;
            ctl <= next_ctl;
            md <= next_md;
            hist <= next_hist;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_off_quiet: assert property (settled && !ctl[15] |->
        !DATA_OE && !READ_STROBE_OE && !WRITE_STROBE_OE)
        else $error("port drives pins while disabled");
    a_idle_hold: assert property (settled && ctl[15] && ctl[13] &&
        CHIP_IDLE && $past(CHIP_IDLE) |-> $stable(ADDR_OUT) &&
        $stable(WRITE_STROBE_OUT) && $stable(DATA_OE))
        else $error("port moved while halted in idle");
    a_ttl_follow: assert property (settled |-> TTL_SELECT == ctl[10])
        else $error("buffer select differs from control");
    a_wr_pin_off: assert property (settled && !ctl[9] |-> !WRITE_STROBE_OE)
        else $error("write strobe driven while its pin is off");
    a_rd_pin_off: assert property (settled && !ctl[8] |-> !READ_STROBE_OE)
        else $error("read strobe driven while its pin is off");
    a_cs_addr: assert property (settled && ctl[15] && md[9] &&
        ctl[7:6] == 2'b00 |-> CS1_OUT == ADDR_OUT[14] &&
        CS2_OUT == ADDR_OUT[15])
        else $error("select pins do not carry address bits");
    a_latch_level: assert property (settled && !ctl[15] |->
        LATCH_LOW_OUT == !ctl[5] && LATCH_HIGH_OUT == !ctl[5])
        else $error("latch idle level wrong for polarity");
    a_event_none: assert property (settled && md[14:13] == 2'b00
        |-> !CYCLE_EVENT) else $error("event raised with events off");
    a_event_pulse: assert property (CYCLE_EVENT |=> !CYCLE_EVENT)
        else $error("event longer than one cycle");
    cover property (CYCLE_EVENT);
    cover property (settled && WRITE_STROBE_OE && !WRITE_STROBE_OUT);
    cover property (settled && ctl[13] && ctl[15] && CHIP_IDLE);
endmodule
bind parallel_port_control parallel_port_control_props u_props (.*);

// ### sim/parallel_port_peer.sv
// far-side byte peripheral answering master port cycles
`timescale 1ns/1ps
module parallel_port_peer (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // port pins
    input wire logic [15:0] ADDR_OUT,
    input wire logic [15:0] DATA_OUT,
    input wire logic DATA_OE,
    input wire logic READ_STROBE_OE,
    input wire logic WRITE_STROBE_OUT,
    input wire logic WRITE_STROBE_OE,
    output logic [15:0] DATA_IN = 16'h0000,
    // observations
    output logic [7:0] last_wr = 8'h00,
    output logic [7:0] wr_cycles = 8'h00
);
    logic wr_on;
    // write strobe polarity bit is kept clear, so active low
    assign wr_on = WRITE_STROBE_OE && !WRITE_STROBE_OUT && DATA_OE;
    always @(posedge MCLK) begin
        if (READ_STROBE_OE && !DATA_OE) DATA_IN <= ADDR_OUT ^ 16'h5A3C;
        else DATA_IN <= ~DATA_IN;
    end
    always @(posedge MCLK) begin
        if (wr_on) begin
            last_wr <= DATA_OUT[7:0];
            wr_cycles <= wr_cycles + 8'h01;
        end
    end
endmodule

// ### sim/tb_parallel_port_control.sv
// self-checking bench for the parallel port control block
`timescale 1ns/1ps
`include "port_ctrl_defines.svh"
module tb_parallel_port_control;
    import port_ctrl_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
    logic MCLK = 1'b0, RST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0;
    logic BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, CHIP_IDLE = 1'b0;
    logic SLAVE_READ_N = 1'b1, SLAVE_WRITE_N = 1'b1, SLAVE_CS_N = 1'b1;
    logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hF;
    logic [31:0] WDATA = 32'h0000_0000, RDATA, rv;
    logic [1:0] SLAVE_ADDR_IN = 2'h0, BRESP, RRESP;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DATA_OE, CS1_OUT;
    logic CS2_OUT, READ_STROBE_OUT, READ_STROBE_OE, WRITE_STROBE_OUT;
    logic WRITE_STROBE_OE, LATCH_LOW_OUT, LATCH_HIGH_OUT, TTL_SELECT;
    logic CYCLE_EVENT;
    logic [15:0] ADDR_OUT, DATA_OUT, DATA_IN;
    logic [7:0] last_wr, wr_cycles;
    note_t notes[$];
    note_t n;
    int num_errors = 0, tests_run = 0, cyc = 0, ev_cnt = 0;
    always #2 MCLK = ~MCLK;
    parallel_port_control uut (.*);
    parallel_port_peer peer (.*);
    task automatic chk(input string nm, input logic [31:0] e, s);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // no new access before the response is taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        // handshakes are read at the edge, before that edge's updates land
        fork
            begin
                do @(posedge MCLK); while (AWREADY !== 1'b1);
                AWVALID <= 1'b0;
            end
            begin
                do @(posedge MCLK); while (WREADY !== 1'b1);
                WVALID <= 1'b0;
            end
        join
        BREADY <= 1'b1;
        do @(posedge MCLK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, m,
                      input logic [1:0] r, output logic [31:0] v);
        @(posedge MCLK);
        notes.push_back('{e, m, r});
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge MCLK); while (RVALID !== 1'b1);
        v = RDATA;
        ARVALID <= 1'b0;
        RREADY <= 1'b0;
    endtask
    task automatic wait_idle();
        logic [31:0] v;
        do rd(4'h4, 32'h0, 32'h0, 2'b00, v); while (v[15] !== 1'b0);
    endtask
    always @(negedge MCLK) begin
        if (RVALID === 1'b1 && RREADY === 1'b1) begin
            n = notes.pop_front();
            chk("rdata", n.d & n.m, RDATA & n.m);
            chk("rresp", {30'h0, n.r}, {30'h0, RRESP});
        end
    end
    // a hang is cut short well past the few hundred cycles needed
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (CYCLE_EVENT === 1'b1) ev_cnt <= ev_cnt + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        logic [15:0] a, st;
        logic [7:0] d, s0;
        logic [3:0] wm;
        logic [1:0] wb, we, md, cf, inc;
        int e0;
        void'($urandom(65));
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
        rd(4'h0, `CTL_RESET, 32'hFFFF_FFFF, 2'b00, rv);
        rd(4'h4, `MOD_RESET, 32'hFFFF_FFFF, 2'b00, rv);
        wr(4'h0, 32'hFFFF_FFFF);
        rd(4'h0, `CTL_MASK, 32'hFFFF_FFFF, 2'b00, rv);
        wr(4'h0, 32'h0000_0000);
        wr(4'h4, 32'hFFFF_FFFF);
        rd(4'h4, `MOD_MASK, 32'hFFFF_FFFF, 2'b00, rv);
        rd(4'h2, 32'h0000_0000, 32'hFFFF_FFFF, 2'b10, rv);
        for (int i = 0; i < 4; i++) begin
            md = i[0] ? 2'b11 : 2'b10;
            cf = i[1] ? 2'b10 : 2'b00;
            inc = (i[0] ^ i[1]) ? 2'b01 : 2'b10;
            wb = 2'($urandom);
            wm = 4'($urandom);
            we = 2'($urandom);
            d = 8'($urandom);
            // step field stays clear of wrap, so no carry into other bits
            a = 16'h0108 | (16'($urandom) & 16'h00F0);
            st = (inc == 2'b01) ? a + 16'h0004 : a - 16'h0004;
            wr(4'h0, 32'h0000_8308 | {24'h0, cf, 6'h00});
            wr(4'h4, {17'h0, 2'b01, inc, 1'b0, md, wb, wm, we});
            wr(4'h8, {16'h0, a});
            e0 = ev_cnt;
            s0 = wr_cycles;
            wr(4'hC, {24'h0, d});
            wait_idle();
            chk("write byte", {24'h0, d}, {24'h0, last_wr});
            chk("strobe", {28'h0, (wm == 4'h0) ? 4'h1 : wm},
                {24'h0, 8'(wr_cycles - s0)});
            chk("event", 32'h1, 32'(ev_cnt - e0));
            rd(4'h8, {16'h0, st}, 32'h0000_FFFF, 2'b00, rv);
            rd(4'hC, 32'h0, 32'h0, 2'b00, rv);
            wait_idle();
            rd(4'hC, {16'h0, st ^ 16'h5A3C}, 32'h0000_00FF, 2'b00, rv);
            wait_idle();
        end
        wr(4'h0, 32'h0000_0020);
        s0 = wr_cycles;
        wr(4'hC, 32'h0000_00A5);
        repeat (10) @(posedge MCLK);
        chk("strobe off", 32'h0, {24'h0, 8'(wr_cycles - s0)});
        rd(4'h4, 32'h0, 32'h0000_8000, 2'b00, rv);
        wr(4'h4, {17'h0, 2'b00, 2'b00, 1'b0, 2'b10, 8'h04});
        CHIP_IDLE <= 1'b1;
        wr(4'h0, 32'h0000_A308);
        e0 = ev_cnt;
        s0 = wr_cycles;
        wr(4'hC, 32'h0000_005A);
        repeat (10) @(posedge MCLK);
        // a halted port refuses the start instead of holding it
        rd(4'h4, 32'h0, 32'h0000_8000, 2'b00, rv);
        chk("strobe idle", 32'h0, {24'h0, 8'(wr_cycles - s0)});
        CHIP_IDLE <= 1'b0;
        wr(4'hC, 32'h0000_005A);
        wait_idle();
        chk("idle byte", 32'h0000_005A, {24'h0, last_wr});
        chk("no event", 32'h0, 32'(ev_cnt - e0));
        summarize();
    end
endmodule
